// [sim/iosa_contact_model.sv]
`timescale 1ns/1ps
// field contacts: each new pattern lands at a shifting point inside the period,
// so the block never sees contact edges lined up with its clock
module iosa_contact_model (
  input wire logic ref_clk,
  input wire logic [6:0] closeCmd,
  output logic [6:0] ioConnector
);
  logic [5:0] ph;
  initial ioConnector = 7'h00;
  initial ph = 6'h05;
  // the phase walks between 5 and 40 ns after the edge
  always @(posedge ref_clk) begin
    ph <= (ph > 6'h27) ? ph - 6'h23 : ph + 6'h07;
    ioConnector <= #(ph) closeCmd;
  end
endmodule // iosa_contact_model

// [sim/iosa_input_signal_allocation_checker.sv]
`timescale 1ns/1ps
// watches routed levels, latch pulses and bus answers at the block's ports
module iosa_input_signal_allocation_checker (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic [6:0] ioConnector,
  input wire logic forwardTravelProhibit,
  input wire logic reverseTravelProhibit,
  input wire logic latchInputOne,
  input wire logic latchInputTwo,
  input wire logic latchInputThree,
  input wire logic [2:0] latchEdgePulse
);
  logic [4:0] fv;
  logic [6:0] prevC;
  logic [3:0] qc, qw, qr;
  assign fv = {latchInputThree, latchInputTwo, latchInputOne, reverseTravelProhibit,
    forwardTravelProhibit};
  function automatic logic [3:0] sat(input logic [3:0] v);
    return (v == 4'hf) ? v : v + 4'h1;
  endfunction
  // cycles since a contact change, a write and reset; a level that moves with none
  // of them recent has skipped the synchroniser or lost an update
  always_ff @(posedge ref_clk) begin
    prevC <= ioConnector;
    qr <= reset ? 4'h0 : sat(qr);
    qc <= (ioConnector != prevC) ? 4'h0 : (reset ? 4'hf : sat(qc));
    qw <= (wb_ack_o && wb_we_i) ? 4'h0 : (reset ? 4'hf : sat(qw));
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  a_ack_after_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("no ack after request");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_has_req: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_unmapped_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i > 8'h18
    |-> wb_dat_o == 32'h0000_0000) else $error("unmapped read not zero");
  a_sel_upper_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i < 8'h14
    |-> wb_dat_o[31:16] == 16'h0000) else $error("selector upper half not zero");
  a_level_has_cause: assert property ($changed(fv) |-> qc inside {[3:8]} || qw <= 4'h4
    || qr <= 4'ha) else $error("level moved without cause");
  a_pulse_once: assert property (latchEdgePulse != 3'h0
    |=> (latchEdgePulse & $past(latchEdgePulse)) == 3'h0) else $error("pulse too long");
  a_pulse_one_lvl: assert property (latchEdgePulse[0] |-> ##[0:1] latchInputOne)
    else $error("latch one pulse without level");
  a_pulse_two_lvl: assert property (latchEdgePulse[1] |-> ##[0:1] latchInputTwo)
    else $error("latch two pulse without level");
  a_pulse_three_lvl: assert property (latchEdgePulse[2] |-> ##[0:1] latchInputThree)
    else $error("latch three pulse without level");
  a_pulse_on_rise: assert property (latchEdgePulse == (fv[4:2] & ~$past(fv[4:2])))
    else $error("latch pulse not on rising level");
  a_reset_clears: assert property (disable iff (1'b0) reset
    |=> !wb_ack_o && fv == 5'h00 && latchEdgePulse == 3'h0) else $error("reset not clean");
  c_write: cover property (wb_ack_o && wb_we_i);
  c_pulse: cover property (latchEdgePulse != 3'h0);
  c_prohibit: cover property ($rose(forwardTravelProhibit));
endmodule // iosa_input_signal_allocation_checker

bind iosa_input_signal_allocation iosa_input_signal_allocation_checker i_chk (
  .ref_clk(ref_clk), .reset(reset), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .ioConnector(ioConnector), .forwardTravelProhibit(forwardTravelProhibit),
  .reverseTravelProhibit(reverseTravelProhibit), .latchInputOne(latchInputOne),
  .latchInputTwo(latchInputTwo), .latchInputThree(latchInputThree),
  .latchEdgePulse(latchEdgePulse));

// [sim/iosa_input_signal_allocation_tb.sv]
`timescale 1ns/1ps
// random routing run checked against a reference of the selector coding
module iosa_input_signal_allocation_tb;
  localparam logic [39:0] RIDX = 40'h43_2222_1110;
  localparam logic [39:0] NIBS = 40'h02_3210_3203;
  localparam logic [9:0] SLASH = 10'h1fc;
  logic ref_clk, reset, wbCyc, wbStb, wbWe;
  logic [7:0] wbAdr;
  logic [3:0] wbSel;
  logic [31:0] wbDatW, rd;
  logic [6:0] closeCmd;
  logic [6:0] lastC;
  logic [15:0] selReg [5];
  wire [31:0] wbDatR;
  wire wbAck;
  wire [6:0] ioConnector;
  wire [9:0] fv;
  wire [2:0] pulse;
  integer failures, comparisons, seed, i, r;
  // free-running 20 MHz clock
  initial begin
    ref_clk = 1'h0;
    forever #25 ref_clk = ~ref_clk;
  end
  iosa_contact_model i_contacts (.ref_clk(ref_clk), .closeCmd(closeCmd),
    .ioConnector(ioConnector));
  iosa_input_signal_allocation i_dut (.ref_clk(ref_clk), .reset(reset), .wb_cyc_i(wbCyc),
    .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel),
    .wb_dat_i(wbDatW), .wb_dat_o(wbDatR), .wb_ack_o(wbAck), .ioConnector(ioConnector),
    .forwardTravelProhibit(fv[0]), .reverseTravelProhibit(fv[1]),
    .forwardExtTorqueLimit(fv[2]), .reverseExtTorqueLimit(fv[3]),
    .homingSlowdownSwitch(fv[4]), .latchInputOne(fv[5]), .latchInputTwo(fv[6]),
    .latchInputThree(fv[7]), .brakingAnswerInput(fv[8]), .forcedHaltInput(fv[9]),
    .latchEdgePulse(pulse));
  task automatic close_out();
    if (failures == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one classic cycle; request held until ack is sampled, timeout ends the run
  task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s,
                    input logic [31:0] d);
    integer k;
    @(posedge ref_clk);
    wbCyc <= 1'h1;
    wbStb <= 1'h1;
    wbWe <= w;
    wbAdr <= a;
    wbSel <= s;
    wbDatW <= d;
    k = 0;
    do begin
      @(posedge ref_clk);
      k++;
    end while (wbAck !== 1'h1 && k < 20);
    rd = wbDatR;
    wbCyc <= 1'h0;
    wbStb <= 1'h0;
    if (wbAck !== 1'h1) begin
      failures++;
      $display("[ERR] ack expected 1 seen 0");
      close_out();
    end
  endtask
  task automatic wreg(input integer n, input logic [15:0] w);
    selReg[n] = w;
    wb(1'h1, 8'(4 * n), 4'h3, {16'($random(seed)), w});
  endtask
  task automatic cfg_all(input logic [79:0] w);
    for (int n = 0; n < 5; n++) wreg(n, w[16*n +: 16]);
  endtask
  // reference: own level per function, then the OR over every shared circuit
  function automatic logic [9:0] expect_funcs(input logic [6:0] c);
    logic [3:0] s;
    logic [2:0] ci [10];
    logic [9:0] own, con, res;
    for (int f = 0; f < 10; f++) begin
      s = selReg[RIDX[4*f +: 4]][4*NIBS[4*f +: 4] +: 4];
      ci[f] = (s >= 4'h9) ? 3'(s - 4'h9) : s[2:0];
      con[f] = (s <= 4'h6 || s >= 4'h9) && !(f >= 5 && f <= 7 && ci[f] >= 3'h4);
      own[f] = con[f] && ((c[ci[f]] == SLASH[f]) ^ (s >= 4'h9));
      if (s == 4'h7) own[f] = !(f >= 5 && f <= 7);
    end
    for (int f = 0; f < 10; f++) begin
      res[f] = own[f];
      for (int g = 0; g < 10; g++) if (con[f] && con[g] && ci[f] == ci[g]) res[f] |= own[g];
    end
    return res;
  endfunction
  // apply contacts, let them settle, then compare levels, status and stored words
  task automatic probe(input logic [6:0] c);
    logic [3:0] s;
    logic [2:0] bad;
    logic [2:0] seen;
    logic [9:0] e;
    logic [9:0] was;
    was = expect_funcs(lastC);
    closeCmd <= c;
    // skip the edges that may still carry a pulse from the last selector write
    repeat (2) @(posedge ref_clk);
    seen = 3'h0;
    repeat (8) begin
      @(posedge ref_clk);
      seen = seen | pulse;
    end
    e = expect_funcs(c);
    lastC = c;
    check("functions", {22'h0, e}, {22'h0, fv});
    check("latch pulses", {29'h0, e[7:5] & ~was[7:5]}, {29'h0, seen});
    wb(1'h0, 8'h14, 4'hf, 32'h0000_0000);
    check("function status", {22'h0, e}, rd);
    for (int j = 0; j < 3; j++) begin
      s = selReg[2][4*j+4 +: 4];
      bad[j] = (s >= 4'h4 && s <= 4'h6) || s >= 4'hd;
    end
    wb(1'h0, 8'h18, 4'hf, 32'h0000_0000);
    check("input status", {13'h0, bad, 9'h0, c}, rd);
    for (int n = 0; n < 5; n++) begin
      wb(1'h0, 8'(4 * n), 4'hf, 32'h0000_0000);
      check("selector word", {16'h0, selReg[n]}, rd);
    end
  endtask
  initial begin
    seed = 32'h995e_5d2a;
    failures = 0;
    comparisons = 0;
    reset = 1'h1;
    wbCyc = 1'h0;
    wbStb = 1'h0;
    wbWe = 1'h0;
    wbAdr = 8'h00;
    wbSel = 4'h0;
    wbDatW = 32'h0000_0000;
    closeCmd = 7'h00;
    lastC = 7'h00;
    for (r = 0; r < 5; r++) selReg[r] = 16'h8888;
    repeat (16) @(posedge ref_clk);
    reset <= 1'h0;
    probe(7'h00);
    // most functions on one circuit, both polarities, prohibits kept normal
    cfg_all(80'h0003_0c00_3213_c3c3_3000);
    probe(7'h08);
    probe(7'h77);
    // forced codes and latch selections the block must refuse
    cfg_all(80'h0008_0800_7d47_8787_7000);
    probe(7'h7f);
    // low lane only, a write to status, an unmapped read
    wb(1'h1, 8'h00, 4'h1, 32'hffff_ff12);
    selReg[0][7:0] = 8'h12;
    wb(1'h1, 8'h14, 4'hf, 32'hffff_ffff);
    wb(1'h0, 8'h1c, 4'hf, 32'h0000_0000);
    check("unmapped read", 32'h0000_0000, rd);
    for (i = 0; i < 64; i++) begin
      r = (i < 16) ? 0 : {$random(seed)} % 5;
      wreg(r, (i < 16) ? {4'(i), 12'($random(seed))} : 16'($random(seed)));
      probe(7'($random(seed)));
    end
    close_out();
  end
endmodule // iosa_input_signal_allocation_tb

// [src/iosa_func_route.sv]
`timescale 1ns/1ps
// decodes one function's selector nibble into a circuit, a polarity and a level
module iosa_func_route (
  input wire logic [3:0] sel,
  input wire logic [iosa_pkg::NUM_CIRCUITS-1:0] circuitClosed,
  input wire logic isSlash,
  input wire logic isEdge,
  input wire logic isLatch,
  output logic active,
  output logic connected,
  output logic [2:0] circuitIdx,
  output logic badSel
);

  logic direct;
  logic inverted;
  logic closed;
  logic normalActive;

  // selector decode
  always_comb begin
    direct = (sel <= iosa_pkg::SEL_LAST_DIRECT);
    inverted = (sel >= iosa_pkg::SEL_FIRST_INV);
    circuitIdx = direct ? sel[2:0] : 3'((sel - iosa_pkg::SEL_FIRST_INV));
    if (!direct && !inverted) begin
      circuitIdx = 3'h0;
    end
    closed = circuitClosed[circuitIdx];
    // slash-named functions assert on a closed contact, others on an open one
    normalActive = isSlash ? closed : ~closed;
    // latches on the upper three circuits are not supported: left inactive
    badSel = isLatch && (direct || inverted)
      && (circuitIdx >= iosa_pkg::LATCH_FIRST_BAD_CIRCUIT);
    connected = (direct || inverted) && !badSel;
    if (sel == iosa_pkg::SEL_FORCE_ON) begin
      active = ~isEdge;
    end else if (sel == iosa_pkg::SEL_FORCE_OFF) begin
      active = 1'b0;
    end else if (badSel) begin
      active = 1'b0;
    end else begin
      active = inverted ? ~normalActive : normalActive;
    end
  end

endmodule // iosa_func_route

// [src/iosa_input_signal_allocation.sv]
// The placing of the registers and the Wishbone slave port were chosen for this implementation.
`timescale 1ns/1ps
// Behaviour
// - functions sharing one input circuit all follow the OR of the inputs involved.
// - selectors 0 to 6 each take the function from one fixed, distinct circuit.
// - under 0 to 6 a slash-named function asserts on a closed contact, others on an open one.
// - selectors 9 to F use the same seven circuits in order with inverted polarity.
// - selector 7 disconnects the function and holds a level function asserted.
// - selector 7 never triggers an edge-processed function.
// - selector 8 disconnects the function and holds it deasserted.
// - the three latches must not be routed to the last three circuits.
// - forward prohibit uses the top digit of its register, reverse the low digit of the next.
// - forward and reverse torque limits use digits two and three of that next register.
// - homing switch takes digit zero, latches one to three take digits one to three.
// - braking answer takes digit two of its register, forced halt digit zero of another.
module iosa_input_signal_allocation (
  input wire logic ref_clk,
  input wire logic reset,
  // classic wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // connector input circuits, high while the contact is closed
  input wire logic [iosa_pkg::NUM_CIRCUITS-1:0] ioConnector,
  // routed function levels, high while asserted
  output logic forwardTravelProhibit,
  output logic reverseTravelProhibit,
  output logic forwardExtTorqueLimit,
  output logic reverseExtTorqueLimit,
  output logic homingSlowdownSwitch,
  output logic latchInputOne,
  output logic latchInputTwo,
  output logic latchInputThree,
  output logic brakingAnswerInput,
  output logic forcedHaltInput,
  // one-cycle pulses on the asserting edge of each latch function
  output logic [2:0] latchEdgePulse
);

  localparam int NF = iosa_pkg::NUM_FUNCS;
  localparam int NC = iosa_pkg::NUM_CIRCUITS;

  // selector registers, one per parameter word
  logic [15:0] fwdProhibitSelectReg;
  logic [15:0] revProhibitTorqueLimitSelectReg;
  logic [15:0] homingLatchSelectReg;
  logic [15:0] brakeAnswerSelectReg;
  logic [15:0] forcedHaltSelectReg;
  logic [15:0] selWords [iosa_pkg::NUM_SEL_REGS];

  // synchronised contacts and per-function decode results
  logic [NC-1:0] circuitClosed;
  logic [NF-1:0] ownActive;
  logic [NF-1:0] connected;
  logic [2:0] circuitIdx [NF];
  logic [NF-1:0] badSel;
  logic [NF-1:0] combined;
  logic [NC-1:0] circuitOr;
  logic [31:0] funcStatusWord;
  logic [31:0] inputStatusWord;

  // registered results
  logic [NF-1:0] funcActiveReg;
  logic [2:0] latchEdgeReg;

  // bus side
  logic ackReg;
  logic [31:0] rdDataReg;
  logic [31:0] rdDataNext;
  logic busReq;
  logic wrStrobe;

  // contacts arrive from the field with no relation to ref_clk; a settled change
  // reaches the function outputs five edges later, and a glitch that lasts one
  // clock is filtered out while anything longer passes
  iosa_input_sync #(
    .WIDTH(NC)
  ) u_sync (
    .ref_clk(ref_clk),
    .reset(reset),
    .rawIn(ioConnector),
    .levelOut(circuitClosed)
  );

  // the selector words as an indexed view for the per-function decode
  always_comb begin
    selWords[0] = fwdProhibitSelectReg;
    selWords[1] = revProhibitTorqueLimitSelectReg;
    selWords[2] = homingLatchSelectReg;
    selWords[3] = brakeAnswerSelectReg;
    selWords[4] = forcedHaltSelectReg;
  end

  // one decoder per function; the nibble is picked by the function's place
  genvar f;
  generate
    for (f = 0; f < NF; f++) begin : g_func
      localparam int RIDX = iosa_pkg::FUNC_REG[f];
      localparam int NIB = iosa_pkg::FUNC_NIB[f];
      logic [3:0] funcSel;

      assign funcSel = selWords[RIDX][NIB*4 +: 4];

      iosa_func_route u_route (
        .sel(funcSel),
        .circuitClosed(circuitClosed),
        .isSlash(iosa_pkg::SLASH_MASK[f]),
        .isEdge(iosa_pkg::EDGE_MASK[f]),
        .isLatch(iosa_pkg::LATCH_MASK[f]),
        .active(ownActive[f]),
        .connected(connected[f]),
        .circuitIdx(circuitIdx[f]),
        .badSel(badSel[f])
      );
    end
  endgenerate

  // sharing a circuit ties functions together: each sees the OR of all sharers.
  // the OR is taken over each sharer's own polarity view, so mixed polarities
  // on one circuit still combine the way software set them up; forced codes and
  // refused latch routes never join, so they cannot drag a sharer along
  genvar c;
  generate
    for (c = 0; c < NC; c++) begin : g_share
      logic orBit;

      always_comb begin
        orBit = 1'b0;
        for (int j = 0; j < NF; j++) begin
          if (connected[j] && (circuitIdx[j] == 3'(c))) begin
            orBit = orBit | ownActive[j];
          end
        end
      end

      assign circuitOr[c] = orBit;
    end
  endgenerate

  // each connected function follows its circuit's OR, any other keeps its own level
  always_comb begin
    for (int i = 0; i < NF; i++) begin
      combined[i] = connected[i] ? circuitOr[circuitIdx[i]] : ownActive[i];
    end
  end

  // function levels are registered so outputs never glitch during decode
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      funcActiveReg <= '0;
    end else begin
      funcActiveReg <= combined;
    end
  end

  // latch edges; a forced-on latch is held low by the decoder, so no edge appears.
  // a selector write that raises a latch level also gives one pulse, so software
  // should retarget a latch only while its capture is not armed
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      latchEdgeReg <= '0;
    end else begin
      latchEdgeReg <= combined[iosa_pkg::F_LATCH_THREE:iosa_pkg::F_LATCH_ONE]
        & ~funcActiveReg[iosa_pkg::F_LATCH_THREE:iosa_pkg::F_LATCH_ONE];
    end
  end

  // function outputs
  assign forwardTravelProhibit = funcActiveReg[iosa_pkg::F_FWD_TRAVEL];
  assign reverseTravelProhibit = funcActiveReg[iosa_pkg::F_REV_TRAVEL];
  assign forwardExtTorqueLimit = funcActiveReg[iosa_pkg::F_FWD_TORQUE];
  assign reverseExtTorqueLimit = funcActiveReg[iosa_pkg::F_REV_TORQUE];
  assign homingSlowdownSwitch = funcActiveReg[iosa_pkg::F_HOMING];
  assign latchInputOne = funcActiveReg[iosa_pkg::F_LATCH_ONE];
  assign latchInputTwo = funcActiveReg[iosa_pkg::F_LATCH_TWO];
  assign latchInputThree = funcActiveReg[iosa_pkg::F_LATCH_THREE];
  assign brakingAnswerInput = funcActiveReg[iosa_pkg::F_BRAKE_ANS];
  assign forcedHaltInput = funcActiveReg[iosa_pkg::F_FORCED_HALT];
  assign latchEdgePulse = latchEdgeReg;

  // bus handshake: ack rises one edge after the request, the write lands at the
  // edge where the master sees ack, and ack drops the cycle after.
  // no wait state is inserted; a master that held stb past ack would start a
  // second access, which the handshake expects it never to do
  assign busReq = wb_cyc_i && wb_stb_i;
  assign wrStrobe = busReq && wb_we_i && ackReg;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ackReg <= 1'b0;
    end else begin
      ackReg <= busReq && !ackReg;
    end
  end

  // byte-lane merge for the 16-bit selector words; upper lanes are dropped
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] wdat,
                                          input logic [3:0] lanes);
    logic [15:0] res;
    res = old;
    if (lanes[0]) begin
      res[7:0] = wdat[7:0];
    end
    if (lanes[1]) begin
      res[15:8] = wdat[15:8];
    end
    return res;
  endfunction

  // selector writes; polarity of the prohibits is left to software to keep, since
  // an inverted prohibit stops tripping on a broken wire and only software knows
  // whether the wiring makes that safe
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      fwdProhibitSelectReg <= iosa_pkg::SEL_RESET;
      revProhibitTorqueLimitSelectReg <= iosa_pkg::SEL_RESET;
      homingLatchSelectReg <= iosa_pkg::SEL_RESET;
      brakeAnswerSelectReg <= iosa_pkg::SEL_RESET;
      forcedHaltSelectReg <= iosa_pkg::SEL_RESET;
    end else if (wrStrobe) begin
      unique case (wb_adr_i)
        iosa_pkg::OFS_FWD_PROHIBIT: begin
          fwdProhibitSelectReg <= merge16(fwdProhibitSelectReg, wb_dat_i, wb_sel_i);
        end
        iosa_pkg::OFS_REV_PROHIBIT_TORQUE: begin
          revProhibitTorqueLimitSelectReg <=
            merge16(revProhibitTorqueLimitSelectReg, wb_dat_i, wb_sel_i);
        end
        iosa_pkg::OFS_HOMING_LATCH: begin
          homingLatchSelectReg <= merge16(homingLatchSelectReg, wb_dat_i, wb_sel_i);
        end
        iosa_pkg::OFS_BRAKE_ANSWER: begin
          brakeAnswerSelectReg <= merge16(brakeAnswerSelectReg, wb_dat_i, wb_sel_i);
        end
        iosa_pkg::OFS_FORCED_HALT: begin
          forcedHaltSelectReg <= merge16(forcedHaltSelectReg, wb_dat_i, wb_sel_i);
        end
        default: begin
          // status words and unmapped offsets ignore writes
        end
      endcase
    end
  end

  // status words assembled apart from the mux so their layout sits in one place
  always_comb begin
    funcStatusWord = 32'h0000_0000;
    funcStatusWord[NF-1:0] = funcActiveReg;
    inputStatusWord = 32'h0000_0000;
    inputStatusWord[NC-1:0] = circuitClosed;
    inputStatusWord[iosa_pkg::STAT_BAD_SEL_POS +: 3] =
      badSel[iosa_pkg::F_LATCH_THREE:iosa_pkg::F_LATCH_ONE];
  end

  // read mux; unmapped offsets read zero but are still acknowledged
  always_comb begin
    rdDataNext = 32'h0000_0000;
    unique case (wb_adr_i)
      iosa_pkg::OFS_FWD_PROHIBIT: begin
        rdDataNext[15:0] = fwdProhibitSelectReg;
      end
      iosa_pkg::OFS_REV_PROHIBIT_TORQUE: begin
        rdDataNext[15:0] = revProhibitTorqueLimitSelectReg;
      end
      iosa_pkg::OFS_HOMING_LATCH: begin
        rdDataNext[15:0] = homingLatchSelectReg;
      end
      iosa_pkg::OFS_BRAKE_ANSWER: begin
        rdDataNext[15:0] = brakeAnswerSelectReg;
      end
      iosa_pkg::OFS_FORCED_HALT: begin
        rdDataNext[15:0] = forcedHaltSelectReg;
      end
      iosa_pkg::OFS_FUNC_STATUS: begin
        rdDataNext = funcStatusWord;
      end
      iosa_pkg::OFS_INPUT_STATUS: begin
        rdDataNext = inputStatusWord;
      end
      default: begin
        rdDataNext = 32'h0000_0000;
      end
    endcase
  end

  // read data is captured as ack rises and held while it stands; a status word
  // thus shows the levels of the request edge, not of the edge the master takes it
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rdDataReg <= 32'h0000_0000;
    end else if (busReq && !ackReg) begin
      rdDataReg <= rdDataNext;
    end
  end

  assign wb_dat_o = rdDataReg;
  assign wb_ack_o = ackReg;

endmodule // iosa_input_signal_allocation

// [src/iosa_input_sync.sv]
`timescale 1ns/1ps
// three-flop synchroniser; the output moves only once stages two and three agree
module iosa_input_sync #(
  parameter int WIDTH = 7
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [WIDTH-1:0] rawIn,
  output logic [WIDTH-1:0] levelOut
);

  logic [WIDTH-1:0] stage1Reg;
  logic [WIDTH-1:0] stage2Reg;
  logic [WIDTH-1:0] stage3Reg;

  // stage one feeds stage two only, so nothing reads a possibly metastable bit
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      stage1Reg <= '0;
      stage2Reg <= '0;
      stage3Reg <= '0;
    end else begin
      stage1Reg <= rawIn;
      stage2Reg <= stage1Reg;
      stage3Reg <= stage2Reg;
    end
  end

  // agreement filter per bit; each bit keeps its own flop so that no two
  // processes write one variable
  genvar b;
  generate
    for (b = 0; b < WIDTH; b++) begin : g_filt
      logic filtReg;
      always_ff @(posedge ref_clk) begin
        if (reset) begin
          filtReg <= 1'b0;
        end else if (stage2Reg[b] == stage3Reg[b]) begin
          filtReg <= stage3Reg[b];
        end
      end
      assign levelOut[b] = filtReg;
    end
  endgenerate

endmodule // iosa_input_sync

// [src/iosa_pkg.sv]
package iosa_pkg;

  // connector input circuits and routable functions
  localparam int NUM_CIRCUITS = 7;
  localparam int NUM_FUNCS = 10;
  localparam int NUM_SEL_REGS = 5;
  localparam int SYNC_STAGES = 3;

  // function indices
  localparam int F_FWD_TRAVEL = 0;
  localparam int F_REV_TRAVEL = 1;
  localparam int F_FWD_TORQUE = 2;
  localparam int F_REV_TORQUE = 3;
  localparam int F_HOMING = 4;
  localparam int F_LATCH_ONE = 5;
  localparam int F_LATCH_TWO = 6;
  localparam int F_LATCH_THREE = 7;
  localparam int F_BRAKE_ANS = 8;
  localparam int F_FORCED_HALT = 9;

  // functions whose name carries the active-low slash prefix
  localparam logic [9:0] SLASH_MASK = 10'h1FC;
  // functions processed on an edge rather than a level (the latches)
  localparam logic [9:0] EDGE_MASK = 10'h0E0;
  localparam logic [9:0] LATCH_MASK = 10'h0E0;

  // selector register index and nibble position of each function
  localparam int FUNC_REG [NUM_FUNCS] = '{0, 1, 1, 1, 2, 2, 2, 2, 3, 4};
  localparam int FUNC_NIB [NUM_FUNCS] = '{3, 0, 2, 3, 0, 1, 2, 3, 2, 0};

  // selector codes
  localparam logic [3:0] SEL_LAST_DIRECT = 4'h6;
  localparam logic [3:0] SEL_FORCE_ON = 4'h7;
  localparam logic [3:0] SEL_FORCE_OFF = 4'h8;
  localparam logic [3:0] SEL_FIRST_INV = 4'h9;
  // latches may not use circuits at or above this index
  localparam logic [2:0] LATCH_FIRST_BAD_CIRCUIT = 3'h4;

  // register byte offsets
  localparam logic [7:0] OFS_FWD_PROHIBIT = 8'h00;
  localparam logic [7:0] OFS_REV_PROHIBIT_TORQUE = 8'h04;
  localparam logic [7:0] OFS_HOMING_LATCH = 8'h08;
  localparam logic [7:0] OFS_BRAKE_ANSWER = 8'h0C;
  localparam logic [7:0] OFS_FORCED_HALT = 8'h10;
  localparam logic [7:0] OFS_FUNC_STATUS = 8'h14;
  localparam logic [7:0] OFS_INPUT_STATUS = 8'h18;

  // reset value of every selector register: all functions unused
  localparam logic [15:0] SEL_RESET = 16'h8888;

  // status field positions
  localparam int STAT_BAD_SEL_POS = 16;

endpackage
